/* rtl/fsr_checksum.v */
// Register and EEPROM signature checksum checker
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.vh"

module fsr_checksum
#(
  parameter PAGE_W = 256,
  parameter EE_W = 256
)
(
  input wire core_clk,
  input wire rst_b,
  input wire [PAGE_W-1:0] pageData,
  input wire calcCmd,
  input wire checkCmd,
  input wire [EE_W-1:0] eepromData,
  input wire [15:0] eepromSigStored,
  input wire scanDone,
  output reg regMismatch_q,
  output reg eepromMismatch_q
);

  reg [15:0] regSig_q;

  // Rotate-and-xor fold into a 16-bit signature
  function [15:0] foldSig;
    input [PAGE_W+EE_W-1:0] vec;
    input integer len;
    integer i;
    reg [15:0] acc;
    begin
      acc = 16'h0000;
      for (i = 0; i < len; i = i + 1)
        acc = {acc[14:0], acc[15] ^ acc[12] ^ acc[3] ^ vec[i]};
      foldSig = acc;
    end
  endfunction

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      regSig_q <= `FSR_SIG_RESET;
      regMismatch_q <= 1'b0;
      eepromMismatch_q <= 1'b0;
    end
    else
    begin
      if (calcCmd)
        regSig_q <= foldSig({{EE_W{1'b0}}, pageData}, PAGE_W);
      regMismatch_q <= checkCmd &&
        (foldSig({{EE_W{1'b0}}, pageData}, PAGE_W) != regSig_q);
      eepromMismatch_q <= scanDone &&
        (foldSig({{PAGE_W{1'b0}}, eepromData}, EE_W) != eepromSigStored);
    end
  end

endmodule // fsr_checksum

`default_nettype wire

/* rtl/fsr_defines.vh */
// Constants for the fault status register group
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// -----------------------------------------------------------------
// Register indices and byte addresses
// -----------------------------------------------------------------
`define FSR_ADDR_W 12
`define FSR_IDX_OPEN_WIRE 10'h083
`define FSR_IDX_OVER_TEMP 10'h084
`define FSR_IDX_GENERAL 10'h085
`define FSR_ADDR_OPEN_WIRE {`FSR_IDX_OPEN_WIRE, 2'b00}
`define FSR_ADDR_OVER_TEMP {`FSR_IDX_OVER_TEMP, 2'b00}
`define FSR_ADDR_GENERAL {`FSR_IDX_GENERAL, 2'b00}
`define FSR_ADDR_CTRL 12'h000
`define FSR_ADDR_IRQ_STATUS 12'h004
`define FSR_ADDR_IRQ_MASK 12'h008

// -----------------------------------------------------------------
// Valid bits, clear values, reset values
// -----------------------------------------------------------------
`define FSR_OW_MASK 16'h7fff
`define FSR_OT_MASK 16'h1f9f
`define FSR_GEN_MASK 16'h000f
`define FSR_OW_CLEAR 16'hffff
`define FSR_OT_CLEAR 16'hffff
`define FSR_GEN_CLEAR 16'h000f
`define FSR_FLAG_RESET 16'h0000
`define FSR_SIG_RESET 16'h0000

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define FSR_OT_INTERNAL 0
`define FSR_OT_EXT_LSB 1
`define FSR_OT_GPIO_LSB 7
`define FSR_OT_OPEN_LSB 9
`define FSR_GEN_UNDERRUN 0
`define FSR_GEN_OVERRUN 1
`define FSR_GEN_EEPROM_ERR 2
`define FSR_GEN_REG_ERR 3
`define FSR_CTRL_OVERRIDE 0
`define FSR_CTRL_CALC 1
`define FSR_CTRL_CHECK 2
`define FSR_IRQ_OPEN_WIRE 0
`define FSR_IRQ_OVER_TEMP 1
`define FSR_IRQ_GENERAL 2
`define FSR_IRQ_W 3

// -----------------------------------------------------------------
// Bus answers
// -----------------------------------------------------------------
`define FSR_RESP_OKAY 2'b00
`define FSR_RESP_SLVERR 2'b10

`endif

/* rtl/fsr_fault_status.v */
// Fault status register group with AXI4-Lite slave and interrupt
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.vh"

// How it works
// - Open-wire register keeps one sticky flag per sense pin, bits 14 to 0.
// - Writing all ones to open-wire or over-temperature register clears it.
// - After override-clear command, next write replaces the register contents.
// - Over-temperature layout: internal bit0, external 1-4, gpio 7-8, open 9-12.
// - Internal over-temperature flag sets on die fault, zero after reset.
// - Writing 000F hexadecimal to general fault register clears it.
// - General fault flags reset to zero, set on their fault condition.
// - Buffer underrun flag sets when memory buffer underrun is detected.
// - Buffer overrun flag sets when memory buffer overrun is detected.
// - After scan, EEPROM signature compared to stored value; mismatch sets flag.
// - Calculate stores page signature; check recomputes, mismatch sets flag.
// - Summary parity fault is OR of register and EEPROM checksum errors.
module fsr_fault_status
#(
  parameter PAGE_W = 256,
  parameter EE_W = 256
)
(
  input wire core_clk,
  input wire rst_b,
  // AXI4-Lite write address
  input wire awvalid,
  output reg awready,
  input wire [`FSR_ADDR_W-1:0] awaddr,
  input wire [2:0] awprot,
  // AXI4-Lite write data
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address
  input wire arvalid,
  output reg arready,
  input wire [`FSR_ADDR_W-1:0] araddr,
  input wire [2:0] arprot,
  // AXI4-Lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Fault detection pulses
  input wire [14:0] openWireFault,
  input wire internalOverTempFault,
  input wire [3:0] externalOverTempFault,
  input wire [1:0] gpioTempFault,
  input wire [3:0] externalOpenFault,
  input wire bufferUnderrun,
  input wire bufferOverrun,
  // Checksum sources
  input wire [PAGE_W-1:0] pageData,
  input wire [EE_W-1:0] eepromData,
  input wire [15:0] eepromSigStored,
  input wire scanDone,
  // Status outputs
  output reg summaryParityFault,
  output reg irq
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  reg awHeld_q;
  reg [`FSR_ADDR_W-1:0] awAddr_q;
  reg wHeld_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg override_q;
  reg calcPulse_q;
  reg checkPulse_q;
  reg [`FSR_IRQ_W-1:0] irqStatus_q;
  reg [`FSR_IRQ_W-1:0] irqMask_q;
  reg [`FSR_IRQ_W-1:0] irqStatus_d;
  wire [15:0] openWireFlags, overTempFlags, generalFlags;
  wire [15:0] openWireSet, overTempSet, generalSet;
  wire regMismatch, eepromMismatch;
  wire awTake, wTake, awHas, wHas, doWrite;
  wire [`FSR_ADDR_W-1:0] wrAddr;
  wire [31:0] wrData;
  wire [3:0] wrStrb;
  wire fullLanes;
  wire wrOpenWire, wrOverTemp, wrGeneral;
  wire wrCtrl, wrIrqStatus, wrIrqMask;
  wire arTake;
  wire [`FSR_IRQ_W-1:0] irqEvents;

  function mappedAddr;
    input [`FSR_ADDR_W-1:0] addr;
    begin
      mappedAddr = (addr == `FSR_ADDR_OPEN_WIRE) || (addr == `FSR_ADDR_OVER_TEMP) ||
                   (addr == `FSR_ADDR_GENERAL) || (addr == `FSR_ADDR_CTRL) ||
                   (addr == `FSR_ADDR_IRQ_STATUS) || (addr == `FSR_ADDR_IRQ_MASK);
    end
  endfunction

  // -----------------------------------------------------------------
  // Write channel
  // -----------------------------------------------------------------
  assign awTake = awvalid && awready;
  assign wTake = wvalid && wready;
  assign awHas = awHeld_q || awTake;
  assign wHas = wHeld_q || wTake;
  assign doWrite = awHas && wHas && !bvalid;
  assign wrAddr = awHeld_q ? awAddr_q : awaddr;
  assign wrData = wHeld_q ? wData_q : wdata;
  assign wrStrb = wHeld_q ? wStrb_q : wstrb;
  // Flags are 16 bits wide; a half-word write could fake a magic value
  assign fullLanes = (wrStrb[1:0] == 2'b11);
  assign wrOpenWire = doWrite && fullLanes && (wrAddr == `FSR_ADDR_OPEN_WIRE);
  assign wrOverTemp = doWrite && fullLanes && (wrAddr == `FSR_ADDR_OVER_TEMP);
  assign wrGeneral = doWrite && fullLanes && (wrAddr == `FSR_ADDR_GENERAL);
  assign wrCtrl = doWrite && wrStrb[0] && (wrAddr == `FSR_ADDR_CTRL);
  assign wrIrqStatus = doWrite && wrStrb[0] && (wrAddr == `FSR_ADDR_IRQ_STATUS);
  assign wrIrqMask = doWrite && wrStrb[0] && (wrAddr == `FSR_ADDR_IRQ_MASK);

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= {`FSR_ADDR_W{1'b0}};
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `FSR_RESP_OKAY;
    end
    else
    begin
      if (awTake && !doWrite)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      else if (doWrite)
        awHeld_q <= 1'b0;
      if (wTake && !doWrite)
      begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      else if (doWrite)
        wHeld_q <= 1'b0;
      // One write in flight: ready drops once a beat is held or answered
      awready <= !(awHas && !doWrite) && !(bvalid && !bready) && !doWrite;
      wready <= !(wHas && !doWrite) && !(bvalid && !bready) && !doWrite;
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp <= mappedAddr(wrAddr) ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Control: override arm and checksum commands
  // -----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      override_q <= 1'b0;
      calcPulse_q <= 1'b0;
      checkPulse_q <= 1'b0;
    end
    else
    begin
      if (wrCtrl && wrData[`FSR_CTRL_OVERRIDE])
        override_q <= 1'b1;
      else if (wrOpenWire || wrOverTemp || wrGeneral)
        override_q <= 1'b0;
      calcPulse_q <= wrCtrl && wrData[`FSR_CTRL_CALC];
      checkPulse_q <= wrCtrl && wrData[`FSR_CTRL_CHECK];
    end
  end

  // -----------------------------------------------------------------
  // Fault registers
  // -----------------------------------------------------------------
  assign openWireSet = {1'b0, openWireFault};
  assign overTempSet = {3'b000, externalOpenFault, gpioTempFault, 2'b00,
                        externalOverTempFault, internalOverTempFault};
  assign generalSet = {12'h000, regMismatch, eepromMismatch,
                       bufferOverrun, bufferUnderrun};

  fsr_flag_reg #(
    .WIDTH(16),
    .VALID_MASK(`FSR_OW_MASK),
    .CLEAR_VALUE(`FSR_OW_CLEAR)
  ) u_openWire (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .setVec(openWireSet),
    .wrEn(wrOpenWire),
    .wrOverride(override_q),
    .wrData(wrData[15:0]),
    .flags_q(openWireFlags)
  );

  fsr_flag_reg #(
    .WIDTH(16),
    .VALID_MASK(`FSR_OT_MASK),
    .CLEAR_VALUE(`FSR_OT_CLEAR)
  ) u_overTemp (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .setVec(overTempSet),
    .wrEn(wrOverTemp),
    .wrOverride(override_q),
    .wrData(wrData[15:0]),
    .flags_q(overTempFlags)
  );

  fsr_flag_reg #(
    .WIDTH(16),
    .VALID_MASK(`FSR_GEN_MASK),
    .CLEAR_VALUE(`FSR_GEN_CLEAR)
  ) u_general (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .setVec(generalSet),
    .wrEn(wrGeneral),
    .wrOverride(override_q),
    .wrData(wrData[15:0]),
    .flags_q(generalFlags)
  );

  fsr_checksum #(
    .PAGE_W(PAGE_W),
    .EE_W(EE_W)
  ) u_checksum (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pageData(pageData),
    .calcCmd(calcPulse_q),
    .checkCmd(checkPulse_q),
    .eepromData(eepromData),
    .eepromSigStored(eepromSigStored),
    .scanDone(scanDone),
    .regMismatch_q(regMismatch),
    .eepromMismatch_q(eepromMismatch)
  );

  // -----------------------------------------------------------------
  // Interrupt status and mask
  // -----------------------------------------------------------------
  assign irqEvents = {|generalSet, |(overTempSet & `FSR_OT_MASK), |openWireSet};

  always @*
  begin
    irqStatus_d = irqStatus_q;
    if (wrIrqStatus)
      irqStatus_d = irqStatus_d & ~wrData[`FSR_IRQ_W-1:0];
    // A new event outranks a same-cycle clear
    irqStatus_d = irqStatus_d | irqEvents;
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      irqStatus_q <= {`FSR_IRQ_W{1'b0}};
      irqMask_q <= {`FSR_IRQ_W{1'b0}};
      irq <= 1'b0;
      summaryParityFault <= 1'b0;
    end
    else
    begin
      irqStatus_q <= irqStatus_d;
      if (wrIrqMask)
        irqMask_q <= wrData[`FSR_IRQ_W-1:0];
      irq <= |(irqStatus_q & irqMask_q);
      summaryParityFault <= generalFlags[`FSR_GEN_REG_ERR] |
                            generalFlags[`FSR_GEN_EEPROM_ERR];
    end
  end

  // -----------------------------------------------------------------
  // Read channel
  // -----------------------------------------------------------------
  assign arTake = arvalid && arready;

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `FSR_RESP_OKAY;
    end
    else
    begin
      arready <= !arTake && !(rvalid && !rready);
      if (arTake)
      begin
        rvalid <= 1'b1;
        rresp <= mappedAddr(araddr) ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
        case (araddr)
          `FSR_ADDR_OPEN_WIRE: rdata <= {16'h0000, openWireFlags};
          `FSR_ADDR_OVER_TEMP: rdata <= {16'h0000, overTempFlags};
          `FSR_ADDR_GENERAL: rdata <= {16'h0000, generalFlags};
          `FSR_ADDR_CTRL: rdata <= {31'h00000000, override_q};
          `FSR_ADDR_IRQ_STATUS: rdata <= {29'h00000000, irqStatus_q};
          `FSR_ADDR_IRQ_MASK: rdata <= {29'h00000000, irqMask_q};
          default: rdata <= 32'h00000000;
        endcase
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

endmodule // fsr_fault_status

`default_nettype wire

/* rtl/fsr_flag_reg.v */
// Sticky fault flag register with magic-value clear and direct write
`timescale 1ns/1ps
`default_nettype none

module fsr_flag_reg
#(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] VALID_MASK = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] CLEAR_VALUE = {WIDTH{1'b1}}
)
(
  input wire core_clk,
  input wire rst_b,
  input wire [WIDTH-1:0] setVec,
  input wire wrEn,
  input wire wrOverride,
  input wire [WIDTH-1:0] wrData,
  output reg [WIDTH-1:0] flags_q
);

  reg [WIDTH-1:0] flags_d;

  // Detection is ORed in last so a fault in the clearing cycle survives
  always @*
  begin
    flags_d = flags_q;
    if (wrEn && wrOverride)
      flags_d = wrData;
    else if (wrEn && (wrData == CLEAR_VALUE))
      flags_d = {WIDTH{1'b0}};
    flags_d = (flags_d | setVec) & VALID_MASK;
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
      flags_q <= {WIDTH{1'b0}};
    else
      flags_q <= flags_d;
  end

endmodule // fsr_flag_reg

`default_nettype wire

/* verif/fsr_fault_status_assertions.sv */
// Port-level checks for the fault status register group
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.vh"

module fsr_fault_status_assertions
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [11:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic [14:0] openWireFault,
  input wire logic internalOverTempFault,
  input wire logic [3:0] externalOverTempFault,
  input wire logic [1:0] gpioTempFault,
  input wire logic [3:0] externalOpenFault,
  input wire logic bufferUnderrun,
  input wire logic bufferOverrun,
  input wire logic scanDone,
  input wire logic summaryParityFault,
  input wire logic irq
);
  // ------
  // Helpers
  // ------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic [11:0] rdAddr_q;
  // Writes count as causes: a mask change or direct write can raise outputs
  wire logic anyCause = (|openWireFault) | internalOverTempFault | (|externalOverTempFault)
    | (|gpioTempFault) | (|externalOpenFault) | bufferUnderrun | bufferOverrun | scanDone
    | awvalid | wvalid;
  always @(posedge core_clk)
  begin
    if (arvalid && arready)
      rdAddr_q <= araddr;
  end
  function automatic logic [31:0] vmask(input logic [11:0] a);
    case (a)
      `FSR_ADDR_OPEN_WIRE: return 32'h0000_7fff;
      `FSR_ADDR_OVER_TEMP: return 32'h0000_1f9f;
      `FSR_ADDR_GENERAL: return 32'h0000_000f;
      `FSR_ADDR_CTRL: return 32'h0000_0001;
      `FSR_ADDR_IRQ_STATUS, `FSR_ADDR_IRQ_MASK: return 32'h0000_0007;
      default: return 32'h0000_0000;
    endcase
  endfunction
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence wrAnswer;
    bvalid && !awready && !wready;
  endsequence
  AST_WR_ANSWER:
    assert property (wrTaken |=> wrAnswer) else $error("write not answered");
  AST_B_STANDS:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
  AST_RD_ANSWER:
    assert property (arvalid && arready |=> rvalid && !arready) else $error("read not answered");
  AST_R_STANDS:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata moved");
  AST_RESERVED_ZERO:
    assert property (rvalid |-> (rdata & ~vmask(rdAddr_q)) == 32'h0) else $error("reserved set");
  AST_UNMAPPED_ERR:
    assert property (rvalid && vmask(rdAddr_q) == 32'h0 |-> rresp == `FSR_RESP_SLVERR)
      else $error("unmapped read not refused");
  AST_RESET_CLEAR:
    assert property (disable iff (1'b0) !rst_b |=> !bvalid && !rvalid && !irq
      && !summaryParityFault) else $error("outputs not cleared by reset");
  AST_PARITY_CAUSE:
    assert property ($rose(summaryParityFault) |-> $past(anyCause, 2) || $past(anyCause, 3)
      || $past(anyCause, 4)) else $error("parity fault without cause");
  AST_IRQ_CAUSE:
    assert property ($rose(irq) |-> $past(anyCause, 2) || $past(anyCause, 3)
      || $past(anyCause, 4)) else $error("interrupt without cause");
endmodule // fsr_fault_status_assertions

bind fsr_fault_status fsr_fault_status_assertions u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .openWireFault(openWireFault), .internalOverTempFault(internalOverTempFault),
  .externalOverTempFault(externalOverTempFault), .gpioTempFault(gpioTempFault),
  .externalOpenFault(externalOpenFault), .bufferUnderrun(bufferUnderrun),
  .bufferOverrun(bufferOverrun), .scanDone(scanDone),
  .summaryParityFault(summaryParityFault), .irq(irq));

`default_nettype wire

/* verif/fsr_fault_status_tb.sv */
// Self-checking bench for the fault status register group
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin nMismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module fsr_fault_status_tb;
  // ------
  // Stimulus and bus tasks
  // ------
  localparam logic [11:0] OW = `FSR_ADDR_OPEN_WIRE;
  localparam logic [11:0] OT = `FSR_ADDR_OVER_TEMP;
  localparam logic [11:0] GF = `FSR_ADDR_GENERAL;
  localparam logic [11:0] CT = `FSR_ADDR_CTRL;
  localparam logic [11:0] IS = `FSR_ADDR_IRQ_STATUS;
  localparam logic [11:0] IM = `FSR_ADDR_IRQ_MASK;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  // Event bits: open-wire, internal, external, gpio, open-input, under, over, scan
  logic [28:0] evt = 29'h0000_0000;
  logic [255:0] pageData = 256'h0, eepromData = 256'h0;
  logic [15:0] eepromSigStored = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid, summaryParityFault, irq;
  logic [1:0] bresp, rresp, bRsp, rRsp;
  logic [31:0] rdata, rDat;
  int compares = 0, nMismatch = 0, cyc = 0;

  fsr_fault_status DUT (.core_clk(core_clk), .rst_b(rst_b), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .openWireFault(evt[28:14]),
    .internalOverTempFault(evt[13]), .externalOverTempFault(evt[12:9]),
    .gpioTempFault(evt[8:7]), .externalOpenFault(evt[6:3]), .bufferUnderrun(evt[2]),
    .bufferOverrun(evt[1]), .pageData(pageData), .eepromData(eepromData),
    .eepromSigStored(eepromSigStored), .scanDone(evt[0]),
    .summaryParityFault(summaryParityFault), .irq(irq));

  initial forever #2 core_clk = ~core_clk;

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w)
    begin
      @(posedge core_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      aw = aw && !awready;
      w = w && !wready;
    end
    // Late bready makes the response wait one cycle
    @(posedge core_clk);
    bready <= 1'b1;
    do @(posedge core_clk); while (!bvalid);
    bRsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    // Late rready makes the read data wait one cycle
    @(posedge core_clk);
    rready <= 1'b1;
    do @(posedge core_clk); while (!rvalid);
    rDat = rdata;
    rRsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rDat, e)
    `CHK(rRsp, `FSR_RESP_OKAY)
  endtask

  // One-cycle event pulse, then time for flags and interrupt to settle
  task automatic fire(input logic [28:0] v);
    @(posedge core_clk);
    evt <= v;
    @(posedge core_clk);
    evt <= 29'h0000_0000;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic results;
    $display("compares=%0d mismatches=%0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  task automatic testReset;
    `CHK(irq, 1'b0)
    rdChk(OW, 32'h0);
    rdChk(OT, 32'h0);
    rdChk(GF, 32'h0);
    $display("reset test done");
  endtask

  task automatic testIrq;
    wr(IM, 32'h7);
    fire({26'h0, 3'b010});
    rdChk(IS, 32'h4);
    `CHK(irq, 1'b1)
    rdChk(GF, 32'h2);
    wr(IS, 32'h4);
    rdChk(IS, 32'h0);
    `CHK(irq, 1'b0)
    wr(IM, 32'h5);
    fire({15'h0, 1'b1, 13'h0});
    rdChk(IS, 32'h2);
    `CHK(irq, 1'b0)
    rdChk(OT, 32'h1);
    wr(IS, 32'h2);
    $display("irq test done");
  endtask

  task automatic testOpenWire;
    fire({15'h4001, 14'h0});
    fire({15'h0002, 14'h0});
    rdChk(OW, 32'h4003);
    wr(OW, 32'h1234);
    rdChk(OW, 32'h4003);
    wr(OW, 32'hffff);
    rdChk(OW, 32'h0);
    fire({15'h7fff, 14'h0});
    rdChk(OW, 32'h7fff);
    $display("open-wire test done");
  endtask

  task automatic testOverTemp;
    fire({15'h0, 1'b1, 4'h1, 2'h2, 4'h8, 3'h0});
    rdChk(OT, 32'h1103);
    wr(OT, 32'hffff);
    rdChk(OT, 32'h0);
    fire({15'h0, 1'b1, 4'hf, 2'h3, 4'hf, 3'h0});
    rdChk(OT, 32'h1f9f);
    wr(CT, 32'h1);
    rdChk(CT, 32'h1);
    wr(OT, 32'hffff);
    rdChk(OT, 32'h1f9f);
    wr(CT, 32'h1);
    wr(OT, 32'h0);
    rdChk(OT, 32'h0);
    $display("over-temp test done");
  endtask

  task automatic testGeneral;
    wr(GF, 32'h000f);
    rdChk(GF, 32'h0);
    fire({26'h0, 3'b100});
    rdChk(GF, 32'h1);
    fire({26'h0, 3'b010});
    rdChk(GF, 32'h3);
    wr(GF, 32'hffff);
    rdChk(GF, 32'h3);
    wr(GF, 32'h000f);
    rdChk(GF, 32'h0);
    $display("general test done");
  endtask

  task automatic testChecksum;
    wr(CT, 32'h2);
    wr(CT, 32'h4);
    rdChk(GF, 32'h0);
    pageData <= 256'h1;
    wr(CT, 32'h4);
    rdChk(GF, 32'h8);
    `CHK(summaryParityFault, 1'b1)
    wr(GF, 32'h000f);
    eepromSigStored <= 16'h0001;
    fire({28'h0, 1'b1});
    rdChk(GF, 32'h4);
    `CHK(summaryParityFault, 1'b1)
    wr(GF, 32'h000f);
    rdChk(GF, 32'h0);
    `CHK(summaryParityFault, 1'b0)
    $display("checksum test done");
  endtask

  task automatic testUnmapped;
    wr(12'h100, 32'h5a5a);
    `CHK(bRsp, `FSR_RESP_SLVERR)
    rd(12'h100);
    `CHK(rRsp, `FSR_RESP_SLVERR)
    `CHK(rDat, 32'h0)
    $display("unmapped test done");
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      nMismatch++;
      results;
    end
  end

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    testReset;
    testIrq;
    testOpenWire;
    testOverTemp;
    testGeneral;
    testChecksum;
    testUnmapped;
    results;
  end
endmodule // fsr_fault_status_tb

`default_nettype wire
